/* File: inc/uart_alias_pkg.sv */
// Purpose: constants and types of the receive/transmit alias block
// Assumes: 125 MHz clock, 8N1 framing, fixed baud rate
// Notes:   byte addresses on a 32-bit word bus
package uart_alias_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ     = 125_000_000;
  localparam int BAUD_RATE  = 115_200;
  localparam int OVS        = 16;
  localparam int OVS_CYCLES = CLK_HZ / (BAUD_RATE * OVS);
  localparam logic [7:0] OVS_RELOAD = 8'(OVS_CYCLES - 1);
  localparam logic [3:0] TICK_LAST  = 4'(OVS - 1);
  localparam logic [3:0] TICK_HALF  = 4'(OVS / 2 - 1);
  localparam logic [2:0] BIT_LAST   = 3'h7;

  // ****************************************
  // fifo geometry
  // ****************************************
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] ALIAS_BASE = 32'h5000_1030;
  localparam logic [31:0] ALIAS_END  = 32'h5000_1070;
  localparam logic [31:0] ALIAS6     = 32'h5000_1048;
  localparam logic [31:0] ALIAS7     = 32'h5000_104c;
  localparam logic [31:0] CTRL_ADDR  = 32'h5000_1080;
  localparam logic [31:0] STAT_ADDR  = 32'h5000_1084;
  localparam logic [31:0] ISTAT_ADDR = 32'h5000_1088;
  localparam logic [31:0] IEN_ADDR   = 32'h5000_108c;
  localparam logic [31:0] ICLR_ADDR  = 32'h5000_1090;

  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_IR_MODE = 1;
  localparam int ST_READY     = 0;
  localparam int ST_OVERRUN   = 1;
  localparam int ST_TX_EMPTY  = 5;
  localparam int INT_W        = 3;
  localparam int INT_RX       = 0;
  localparam int INT_OVR      = 1;
  localparam int INT_TXE      = 2;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } busReq_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rxState_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} txState_t;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [PTR_W-1:0]      head;
    logic [PTR_W-1:0]      tail;
    logic [CNT_W-1:0]      count;
  } fifo_t;

  typedef struct packed {
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic [7:0]       ovsCnt;
    logic             fifoEn;
    logic             irMode;
    logic             ovrFlag;
    logic [INT_W-1:0] ist;
    logic [INT_W-1:0] ien;
    fifo_t            rx;
    fifo_t            tx;
    rxState_t         rxSt;
    logic [3:0]       rxTicks;
    logic [2:0]       rxBits;
    logic [7:0]       rxShift;
    txState_t         txSt;
    logic [3:0]       txTicks;
    logic [2:0]       txBits;
    logic [7:0]       txShift;
    logic             txLine;
    logic             serOut;
    logic             irOutN;
    logic             irq;
    logic [31:0]      rdata;
  } state_t;

endpackage

/* File: design/uart_alias.sv */
// Purpose: receive/transmit alias words of a serial port, with its fifos
// Assumes: one clock, plain strobe register port, 8N1 frames
// Notes:   a change of fifo mode flushes both fifos
// Functional notes
// RULE_01: sixteen consecutive word locations all alias the rx/tx data.
// RULE_02: an alias read gives the serial or infrared received byte in 7:0.
// RULE_03: the byte is meaningful only while data-ready is set.
// RULE_04: without fifos a new byte overwrites an unread one, flags overrun.
// RULE_05: with fifos an alias read returns the receive fifo head.
// RULE_06: a byte at a full receive fifo is dropped, contents kept, overrun.
// RULE_07: an alias write sends a byte, on the low-active infrared line too.
// RULE_08: software writes only while transmit-holding-empty is set.
// RULE_09: without fifos one write clears transmit-holding-empty.
// RULE_10: without fifos further writes overwrite the held byte.
// RULE_11: with fifos up to sixteen writes are taken before full.
// RULE_12: a write to a full transmit fifo is dropped, contents unchanged.
// RULE_13: every alias word pops and pushes the same two fifos.
// RULE_14: bits 15:8 read zero, writes to them ignored, data resets to zero.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps

module uart_alias
  import uart_alias_pkg::*;
(
  input  wire logic                  clk,     // 125 MHz clock
  input  wire logic                  rst_n,   // async reset, active low
  input  wire uart_alias_pkg::busReq_t busReq, // register request
  output      logic [31:0]           rdata,   // read data, cycle after rd
  input  wire logic                  serIn,   // serial receive line
  input  wire logic                  irInN,   // infrared receive, active low
  output      logic                  serOut,  // serial transmit line
  output      logic                  irOutN,  // infrared transmit, active low
  output      logic                  irq      // level interrupt
);
  import uart_alias_pkg::*;

  state_t s;
  state_t next_s;

  logic       tick;
  logic       rxLine;
  logic       isAlias;
  logic       aliasRd;
  logic       aliasWr;
  logic       rxPush;
  logic       txPop;
  logic       rxOvr;
  logic       rxFull;
  logic       statusRd;
  logic [7:0] rxHeadByte;
  logic [7:0] txHeadByte;
  logic [7:0] wrByte;
  logic [INT_W-1:0] events;
  logic [INT_W-1:0] clrBits;

  // ****************************************
  // fifo step, shared by both directions
  // ****************************************
  // without fifos the capacity is one and a push onto a held entry
  // overwrites it; with fifos a push onto a full fifo is dropped
  function automatic fifo_t fifoStep(input fifo_t f, input logic en,
                                     input logic push, input logic [7:0] d,
                                     input logic pop);
    fifo_t n;
    logic  full;
    logic  popping;
    n       = f;
    full    = f.count >= (en ? CNT_FULL : CNT_ONE);
    popping = pop && (f.count != '0);
    if (popping) begin
      n.head  = f.head + 1'b1;
      n.count = f.count - 1'b1;
    end
    if (push) begin
      if (!full || popping) begin
        n.mem[f.tail] = d;
        n.tail        = f.tail + 1'b1;
        n.count       = n.count + 1'b1;
      end else if (!en) begin
        n.mem[f.head] = d;
      end
    end
    return n;
  endfunction

  assign rxHeadByte = s.rx.mem[s.rx.head];
  assign txHeadByte = s.tx.mem[s.tx.head];
  assign wrByte     = busReq.wdata[7:0];

  always_comb begin
    next_s = s;

    // ****************************************
    // input synchronisers and oversample divider
    // ****************************************
    next_s.sync1 = {serIn, irInN};
    next_s.sync2 = s.sync1;
    tick          = (s.ovsCnt == '0);
    next_s.ovsCnt = tick ? OVS_RELOAD : s.ovsCnt - 1'b1;
    // infrared pulses are low for a zero bit, so the level maps directly
    rxLine = s.irMode ? s.sync2[0] : s.sync2[1]; // RULE_02

    // ****************************************
    // register decode
    // ****************************************
    isAlias = (busReq.addr >= ALIAS_BASE) && (busReq.addr < ALIAS_END)
              && (busReq.addr[1:0] == 2'b00); // RULE_01
    aliasRd = busReq.rd && isAlias; // RULE_13
    aliasWr = busReq.wr && isAlias; // RULE_13
    statusRd = busReq.rd && (busReq.addr == STAT_ADDR);
    clrBits = '0;
    next_s.rdata = '0;
    if (busReq.rd) begin
      if (isAlias) begin
        next_s.rdata = {24'h0, rxHeadByte}; // RULE_05 RULE_14
      end else begin
        case (busReq.addr)
          CTRL_ADDR: begin
            next_s.rdata[CTRL_FIFO_EN] = s.fifoEn;
            next_s.rdata[CTRL_IR_MODE] = s.irMode;
          end
          STAT_ADDR: begin
            next_s.rdata[ST_READY]    = (s.rx.count != '0); // RULE_03
            next_s.rdata[ST_OVERRUN]  = s.ovrFlag;
            next_s.rdata[ST_TX_EMPTY] = (s.tx.count == '0);
          end
          ISTAT_ADDR: next_s.rdata[INT_W-1:0] = s.ist;
          IEN_ADDR:   next_s.rdata[INT_W-1:0] = s.ien;
          default:    next_s.rdata = '0;
        endcase
      end
    end
    if (busReq.wr) begin
      case (busReq.addr)
        CTRL_ADDR: begin
          next_s.fifoEn = busReq.wdata[CTRL_FIFO_EN];
          next_s.irMode = busReq.wdata[CTRL_IR_MODE];
        end
        IEN_ADDR:  next_s.ien = busReq.wdata[INT_W-1:0];
        ICLR_ADDR: clrBits    = busReq.wdata[INT_W-1:0];
        default:   clrBits    = '0;
      endcase
    end

    // ****************************************
    // receiver
    // ****************************************
    rxPush = 1'b0;
    case (s.rxSt)
      RX_IDLE: begin
        if (tick && !rxLine) begin
          next_s.rxSt    = RX_START;
          next_s.rxTicks = '0;
        end
      end
      RX_START: begin
        if (tick) begin
          next_s.rxTicks = s.rxTicks + 1'b1;
          if (s.rxTicks == TICK_HALF) begin
            // a glitch shorter than half a bit is not a start bit
            next_s.rxSt    = rxLine ? RX_IDLE : RX_DATA;
            next_s.rxTicks = '0;
            next_s.rxBits  = '0;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          next_s.rxTicks = s.rxTicks + 1'b1;
          if (s.rxTicks == TICK_LAST) begin
            next_s.rxShift = {rxLine, s.rxShift[7:1]};
            next_s.rxBits  = s.rxBits + 1'b1;
            if (s.rxBits == BIT_LAST) begin
              next_s.rxSt = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          next_s.rxTicks = s.rxTicks + 1'b1;
          // framing is not checked; the byte is kept either way
          if (s.rxTicks == TICK_LAST) begin
            rxPush      = 1'b1;
            next_s.rxSt = RX_IDLE;
          end
        end
      end
      default: next_s.rxSt = RX_IDLE;
    endcase

    rxFull = s.rx.count >= (s.fifoEn ? CNT_FULL : CNT_ONE);
    rxOvr  = rxPush && rxFull && !(aliasRd && s.rx.count != '0); // RULE_04
    next_s.rx = fifoStep(s.rx, s.fifoEn, rxPush, s.rxShift,
                         aliasRd); // RULE_04 RULE_05 RULE_06

    // ****************************************
    // transmitter
    // ****************************************
    txPop = 1'b0;
    case (s.txSt)
      TX_IDLE: begin
        if (tick && s.tx.count != '0) begin
          txPop          = 1'b1;
          next_s.txShift = txHeadByte;
          next_s.txLine  = 1'b0;
          next_s.txTicks = '0;
          next_s.txSt    = TX_START;
        end
      end
      TX_START: begin
        if (tick) begin
          next_s.txTicks = s.txTicks + 1'b1;
          if (s.txTicks == TICK_LAST) begin
            next_s.txLine = s.txShift[0];
            next_s.txBits = '0;
            next_s.txSt   = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          next_s.txTicks = s.txTicks + 1'b1;
          if (s.txTicks == TICK_LAST) begin
            next_s.txShift = {1'b0, s.txShift[7:1]};
            next_s.txLine  = s.txShift[1];
            next_s.txBits  = s.txBits + 1'b1;
            if (s.txBits == BIT_LAST) begin
              next_s.txLine = 1'b1;
              next_s.txSt   = TX_STOP;
            end
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          next_s.txTicks = s.txTicks + 1'b1;
          if (s.txTicks == TICK_LAST) begin
            next_s.txSt = TX_IDLE;
          end
        end
      end
      default: next_s.txSt = TX_IDLE;
    endcase

    // writes are taken whatever the empty flag shows
    next_s.tx = fifoStep(s.tx, s.fifoEn, aliasWr, wrByte,
                         txPop); // RULE_09 RULE_10 RULE_11 RULE_12

    // changing fifo mode flushes both directions
    if (next_s.fifoEn != s.fifoEn) begin
      next_s.rx.head  = '0;
      next_s.rx.tail  = '0;
      next_s.rx.count = '0;
      next_s.tx.head  = '0;
      next_s.tx.tail  = '0;
      next_s.tx.count = '0;
    end

    next_s.serOut = s.irMode ? 1'b1 : next_s.txLine;
    next_s.irOutN = s.irMode ? next_s.txLine : 1'b1; // RULE_07

    // ****************************************
    // line status and interrupts
    // ****************************************
    // a new overrun in the cycle of the status read is kept
    next_s.ovrFlag = (s.ovrFlag && !statusRd) || rxOvr; // RULE_04 RULE_06
    events[INT_RX]  = rxPush && !rxOvr;
    events[INT_OVR] = rxOvr;
    events[INT_TXE] = txPop && (s.tx.count == CNT_ONE) && !aliasWr;
    next_s.ist = (s.ist & ~clrBits) | events;
    next_s.irq = |(next_s.ist & next_s.ien);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s        <= '0;
      s.sync1  <= 2'b11;
      s.sync2  <= 2'b11;
      s.txLine <= 1'b1;
      s.serOut <= 1'b1;
      s.irOutN <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata  = s.rdata;
  assign serOut = s.serOut;
  assign irOutN = s.irOutN;
  assign irq    = s.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence aliasPop;
    aliasRd && (s.rx.count != '0) && !rxPush;
  endsequence

  sequence irLoad;
    txPop && s.irMode;
  endsequence

  alias_read_data_a: assert property ( // RULE_05
    aliasRd |=> rdata[7:0] == $past(rxHeadByte))
    else $error("alias read returned wrong byte");

  alias_reserved_zero_a: assert property ( // RULE_14
    aliasRd |=> rdata[31:8] == '0)
    else $error("alias upper bits not zero");

  ready_flag_a: assert property ( // RULE_03
    statusRd |=> rdata[ST_READY] == ($past(s.rx.count) != '0))
    else $error("data ready flag wrong");

  rx_overwrite_a: assert property ( // RULE_04
    (!s.fifoEn && rxPush && s.rx.count == CNT_ONE && !aliasRd
     && !busReq.wr) |=> (s.rx.count == CNT_ONE) && s.ovrFlag)
    else $error("single buffer overrun not handled");

  rx_full_keep_a: assert property ( // RULE_06
    (s.fifoEn && rxPush && s.rx.count == CNT_FULL && !aliasRd
     && !busReq.wr) |=> (s.rx.count == CNT_FULL) && $stable(s.rx.tail)
     && s.ovrFlag)
    else $error("full receive fifo changed");

  alias_pop_a: assert property ( // RULE_13
    aliasPop and (s.fifoEn == next_s.fifoEn)
    |=> s.rx.count == $past(s.rx.count) - CNT_ONE)
    else $error("alias read did not pop");

  holding_clear_a: assert property ( // RULE_09
    (!s.fifoEn && aliasWr && s.tx.count == '0 && s.fifoEn == next_s.fifoEn)
    |=> s.tx.count == CNT_ONE)
    else $error("holding empty not cleared");

  holding_overwrite_a: assert property ( // RULE_10
    (!s.fifoEn && aliasWr && s.tx.count == CNT_ONE && !txPop
     && s.fifoEn == next_s.fifoEn) |=> txHeadByte == $past(wrByte))
    else $error("held byte not overwritten");

  tx_accept_a: assert property ( // RULE_11
    (s.fifoEn && aliasWr && s.tx.count < CNT_FULL && !txPop)
    |=> s.tx.count == $past(s.tx.count) + CNT_ONE)
    else $error("fifo write not accepted");

  tx_full_drop_a: assert property ( // RULE_12
    (s.fifoEn && aliasWr && s.tx.count == CNT_FULL && !txPop)
    |=> (s.tx.count == CNT_FULL) && $stable(s.tx.tail))
    else $error("write to full fifo not dropped");

  ir_start_bit_a: assert property ( // RULE_07
    irLoad |=> !irOutN && serOut [*2])
    else $error("infrared start bit not driven");

endmodule

/* File: bench/uart_far_end.sv */
// Purpose: far-end serial/infrared port facing the alias block
// Assumes: 8N1 frames, same bit time as the block's transmitter
// Notes:   both receive lines rest high between frames
`timescale 1ns/1ps

module uart_far_end (
  input  wire logic clk,    // block clock
  input  wire logic irSel,  // listen on the infrared line
  input  wire logic serOut, // block serial output
  input  wire logic irOutN, // block infrared output, active low
  output      logic serIn,  // block serial input
  output      logic irInN   // block infrared input, active low
);
  import uart_alias_pkg::*;
  localparam int BIT = OVS_CYCLES * OVS;
  logic [7:0] rxQ[$];
  wire        watched = irSel ? irOutN : serOut;
  initial begin
    serIn = 1'b1;
    irInN = 1'b1;
  end
  // start, data lsb first, stop, one idle bit so frames never touch
  task automatic sendByte(input logic [7:0] b, input logic ir);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      if (ir) begin
        irInN <= f[i];
      end else begin
        serIn <= f[i];
      end
      repeat (BIT - 1) @(posedge clk);
    end
  endtask
  // samples mid-bit, so a slightly short stop bit is still taken
  always begin : listen
    logic [7:0] b;
    @(negedge watched);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = watched;
    end
    repeat (BIT) @(posedge clk);
    rxQ.push_back(b);
  end
endmodule

/* File: bench/test_uart_alias.sv */
// Purpose: self-checking bench of the receive/transmit alias block
// Assumes: far-end model on both serial and infrared lines
// Notes:   full baud rate, so each scenario spends whole frames
`timescale 1ns/1ps

module test_uart_alias;
  import uart_alias_pkg::*;

  localparam logic [31:0] ALIAS15 = 32'h5000_106c;
  logic        clk;
  logic        rst_n;
  busReq_t     req;
  logic [31:0] rdata;
  logic        serIn;
  logic        irInN;
  logic        serOut;
  logic        irOutN;
  logic        irq;
  logic        irSel;
  int          errTotal;
  int          checksDone;

  uart_alias DUT (.clk(clk), .rst_n(rst_n), .busReq(req), .rdata(rdata),
    .serIn(serIn), .irInN(irInN), .serOut(serOut), .irOutN(irOutN),
    .irq(irq));
  uart_far_end far (.clk(clk), .irSel(irSel), .serOut(serOut),
    .irOutN(irOutN), .serIn(serIn), .irInN(irInN));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [31:0] a, exp, input string what);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd   <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask
  task automatic waitQ(input int n);
    for (int i = 0; i < 40000 && far.rxQ.size() < n; i++) begin
      @(posedge clk);
    end
    check("far bytes", 32'(far.rxQ.size()), 32'(n));
  endtask
  task automatic afterReset();
    rdChk(ALIAS6, 32'h0, "alias reset");
    rdChk(STAT_ADDR, 32'h20, "status reset");
    rdChk(ALIAS_END, 32'h0, "unmapped");
    check("irq reset", 32'(irq), 32'h0);
  endtask
  task automatic serialNoFifo();
    fork
      begin
        far.sendByte(8'h3c, 1'b0);
        far.sendByte(8'ha5, 1'b0);
      end
      begin
        wr(ALIAS_BASE, 32'h0000_ab81);
        waitClk(200);
        rdChk(STAT_ADDR, 32'h20, "tx empty set");
        wr(ALIAS6, 32'h42);
        rdChk(STAT_ADDR, 32'h0, "tx empty clear");
        wr(ALIAS7, 32'h24);
      end
    join
    waitClk(400);
    check("irq masked", 32'(irq), 32'h0);
    wr(IEN_ADDR, 32'h3);
    waitClk(3);
    check("irq raised", 32'(irq), 32'h1);
    rdChk(STAT_ADDR, 32'h23, "overrun");
    rdChk(ALIAS7, 32'ha5, "rx overwrite");
    rdChk(STAT_ADDR, 32'h20, "drained");
    rdChk(ISTAT_ADDR, 32'h7, "status");
    wr(ICLR_ADDR, 32'h3);
    waitClk(3);
    check("irq cleared", 32'(irq), 32'h0);
    rdChk(ISTAT_ADDR, 32'h4, "status left");
    waitQ(2);
    check("tx first", 32'(far.rxQ[0]), 32'h81);
    check("tx overwritten", 32'(far.rxQ[1]), 32'h24);
    far.rxQ.delete();
  endtask
  task automatic fifoMode();
    wr(CTRL_ADDR, 32'h1);
    fork
      begin
        far.sendByte(8'h11, 1'b0);
        far.sendByte(8'h22, 1'b0);
      end
      begin
        wr(ALIAS15, 32'h01);
        wr(ALIAS15, 32'h02);
        wr(ALIAS15, 32'h03);
      end
    join
    waitClk(400);
    rdChk(ALIAS15, 32'h11, "fifo head");
    rdChk(ALIAS_BASE, 32'h22, "fifo next");
    rdChk(STAT_ADDR, 32'h20, "fifo empty");
    waitQ(3);
    for (int i = 0; i < 3; i++) begin
      check("tx queued", 32'(far.rxQ[i]), 32'(i + 1));
    end
    far.rxQ.delete();
  endtask
  task automatic infraredMode();
    wr(CTRL_ADDR, 32'h2);
    irSel <= 1'b1;
    fork
      far.sendByte(8'h96, 1'b1);
      begin
        wr(ALIAS6, 32'h69);
        waitClk(2000);
        check("serial idle", 32'(serOut), 32'h1);
      end
    join
    waitClk(400);
    rdChk(ALIAS7, 32'h96, "ir receive");
    waitQ(1);
    check("ir send", 32'(far.rxQ[0]), 32'h69);
  endtask
  // three scenarios need about 70k cycles
  initial begin
    repeat (95000) @(posedge clk);
    errTotal++;
    endSim();
  end
  initial begin
    errTotal = 0;
    checksDone = 0;
    rst_n = 1'b0;
    req = '0;
    irSel = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    afterReset();
    serialNoFifo();
    fifoMode();
    infraredMode();
    endSim();
  end
endmodule
